// *** verilog/btc_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing figures
 * of the batch totalizer control block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
`ifndef BTC_REGS_SVH
`define BTC_REGS_SVH
// Register byte offsets
`define BTC_CTRL          8'h00
`define BTC_BATCH_TARGET  8'h04
`define BTC_PREWARN_TGT   8'h08
`define BTC_MANUAL_PREACT 8'h0c
`define BTC_DROPOUT       8'h10
`define BTC_DESIGN_RATE   8'h14
`define BTC_INT_RES       8'h18
`define BTC_EXT_RES       8'h1c
`define BTC_CLOSURE       8'h20
`define BTC_COMMAND       8'h24
`define BTC_TOTAL1        8'h28
`define BTC_TOTAL2        8'h2c
`define BTC_VERIFY_TOTAL  8'h30
`define BTC_MTEST_TOTAL   8'h34
`define BTC_BATCH_TOTAL   8'h38
`define BTC_PREACT_OFS    8'h3c
`define BTC_STATUS        8'h40
`define BTC_DISPLAY       8'h44
// Reset values
`define BTC_CTRL_RST      32'h0000_0040
`define BTC_DROPOUT_RST   32'h0000_001e
`define BTC_INT_RES_RST   15'h4924
`define BTC_EXT_RES_RST   6'h24
`define BTC_CLOSURE_RST   8'h03
// Command fields
`define BTC_CMD_BATCH_RST 2
// Timing: closure steps in ms, clock in MHz, rate sample period in ms
`define BTC_STEP_MS       10
`define BTC_CLK_MHZ       100
`define BTC_SAMPLE_MS     100
`define BTC_STEP_CYCLES   (`BTC_STEP_MS * 1000 * `BTC_CLK_MHZ)
`endif

// *** verilog/btc_pkg.sv ***
/*
 * Types of the batch totalizer control block.
 * Assumes btc_regs.svh for all numeric constants.
 */
package btc_pkg;
  // Control register layout
  typedef struct packed {
    logic [22:0] unused;
    logic        verify_active;
    logic [1:0]  total_display_select;
    logic [1:0]  verification_total_mode;
    logic [1:0]  preact_mode;
    logic        prewarn_enable;
    logic        batch_mode_select;
  } btc_ctrl_s;
  // Avalon-MM request from the bus master
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } btc_avs_req_s;
  // Closure duration scanner states, Gray from idle through run to load
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN  = 2'b01,
    SCAN_LOAD = 2'b11
  } btc_scan_e;
endpackage

// *** verilog/btc_top.sv ***
/*
 * Batch control and totalizers of a belt weighing integrator: five
 * internal totalizers, two pulsed external totalizers, batch and
 * pre-warn relays, all set up over an Avalon-MM slave.
 * Assumes rate samples arrive on core_clk with a one-cycle strobe.
 */
`timescale 1ns/100ps
`include "btc_regs.svh"

module btc_top
  import btc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `BTC_STEP_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [3:0]         avs_byteenable,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic signed [31:0] rate_sample,
  input  wire logic               rate_strobe,
  output logic                    batch_relay,
  output logic                    prewarn_relay,
  output logic                    external_count_one,
  output logic                    external_count_two
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Resolution code to step in thousandths of a unit
  function automatic logic [31:0] step_of(input logic [2:0] code);
    case (code)
      3'h1:    step_of = 32'h0000_0001;
      3'h2:    step_of = 32'h0000_000a;
      3'h3:    step_of = 32'h0000_0064;
      3'h5:    step_of = 32'h0000_2710;
      3'h6:    step_of = 32'h0001_86a0;
      3'h7:    step_of = 32'h000f_4240;
      default: step_of = 32'h0000_03e8;
    endcase
  endfunction

  // True when pulses of d steps keep pace with rate dr at pct percent
  function automatic logic keeps_pace(input logic [7:0] d,
                                      input logic [31:0] dr,
                                      input logic [2:0] code,
                                      input logic [7:0] pct);
    logic [63:0] need;
    logic [63:0] have;
    need = 64'(d) * 64'(dr) * 64'(pct) / 64'd5;
    have = 64'(`BTC_SAMPLE_MS) * 64'(step_of(code));
    keeps_pace = need <= have;
  endfunction

  // First resolution at or above code that keeps pace at full rate
  function automatic logic [2:0] eff_res(input logic [2:0] code,
                                         input logic [31:0] dr);
    logic       found;
    logic [2:0] r;
    found = 1'b0;
    eff_res = 3'h7;
    for (int i = 1; i <= 7; i++) begin
      r = 3'(i);
      if (!found && r >= code && keeps_pace(8'h01, dr, r, 8'h64)) begin
        eff_res = r;
        found = 1'b1;
      end
    end
  endfunction

  // Byte-enable merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  btc_avs_req_s       req;
  btc_ctrl_s          ctrl;
  logic [31:0]        batch_target;
  logic [31:0]        prewarn_target;
  logic [31:0]        manual_preact_amount;
  logic [31:0]        totalize_dropout_limit;
  logic [31:0]        design_rate;
  logic [14:0]        internal_total_resolution;
  logic [5:0]         external_total_resolution;
  logic [7:0]         pulse_closure_duration [2];
  logic signed [31:0] preact_offset;
  logic signed [31:0] tot_count [5];
  logic signed [31:0] tot_resid [5];
  logic signed [31:0] next_count [5];
  logic signed [31:0] next_resid [5];
  logic signed [31:0] ext_resid [2];
  logic [31:0]        ext_timer [2];
  logic               ext_on [2];
  logic [2:0]         ext_res_eff [2];
  logic [7:0]         dur_max150 [2];
  logic [7:0]         dur_max100 [2];
  logic [7:0]         dur_eff [2];
  btc_scan_e          scan_state;
  logic [7:0]         scan_d;
  logic               scan_start;
  logic               accept;
  logic               wr;
  logic               rate_pass;
  logic               main_en;
  logic [4:0]         tot_en;
  logic [1:0]         clr_cmd;
  logic               batch_reset;
  logic signed [31:0] trip_point;
  logic signed [63:0] drop_lhs;
  logic signed [63:0] drop_rhs;

  assign req = '{avs_address, avs_read, avs_write, avs_byteenable,
                 avs_writedata};
  assign accept = (req.read | req.write) & avs_waitrequest;
  assign wr = accept & req.write;
  assign clr_cmd = (wr && req.address == `BTC_COMMAND && req.byteenable[0])
                   ? req.writedata[1:0] : 2'h0;
  assign batch_reset = wr && req.address == `BTC_COMMAND &&
                       req.byteenable[0] &&
                       req.writedata[`BTC_CMD_BATCH_RST];
  assign scan_start = wr && (req.address == `BTC_DESIGN_RATE ||
                             req.address == `BTC_EXT_RES);

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, answer at the second edge

  // Waitrequest drops for one cycle after each request
  always_ff @(posedge core_clk) begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~accept;
  end

  // Configuration registers written by software
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl                      <= `BTC_CTRL_RST;
      batch_target              <= 32'h0;
      prewarn_target            <= 32'h0;
      manual_preact_amount      <= 32'h0;
      totalize_dropout_limit    <= `BTC_DROPOUT_RST;
      design_rate               <= 32'h0;
      internal_total_resolution <= `BTC_INT_RES_RST;
      external_total_resolution <= `BTC_EXT_RES_RST;
    end else if (wr) begin
      case (req.address)
        `BTC_CTRL:          ctrl <= merge(ctrl, req.writedata,
                                          req.byteenable);
        `BTC_BATCH_TARGET:  batch_target <= merge(batch_target,
                              req.writedata, req.byteenable);
        `BTC_PREWARN_TGT:   prewarn_target <= merge(prewarn_target,
                              req.writedata, req.byteenable);
        `BTC_MANUAL_PREACT: manual_preact_amount <= merge(
                              manual_preact_amount, req.writedata,
                              req.byteenable);
        `BTC_DROPOUT:       totalize_dropout_limit <= merge(
                              totalize_dropout_limit, req.writedata,
                              req.byteenable);
        `BTC_DESIGN_RATE:   design_rate <= merge(design_rate,
                              req.writedata, req.byteenable);
        `BTC_INT_RES:       internal_total_resolution <= 15'(merge(
                              32'(internal_total_resolution),
                              req.writedata, req.byteenable));
        `BTC_EXT_RES:       external_total_resolution <= 6'(merge(
                              32'(external_total_resolution),
                              req.writedata, req.byteenable));
        default: ;
      endcase
    end
  end

  // Read mux; unmapped and write-only offsets read as zero
  always_ff @(posedge core_clk) begin
    if (reset)
      avs_readdata <= 32'h0;
    else if (accept && req.read) begin
      case (req.address)
        `BTC_CTRL:          avs_readdata <= ctrl;
        `BTC_BATCH_TARGET:  avs_readdata <= batch_target;
        `BTC_PREWARN_TGT:   avs_readdata <= prewarn_target;
        `BTC_MANUAL_PREACT: avs_readdata <= manual_preact_amount;
        `BTC_DROPOUT:       avs_readdata <= totalize_dropout_limit;
        `BTC_DESIGN_RATE:   avs_readdata <= design_rate;
        `BTC_INT_RES:       avs_readdata <= 32'(internal_total_resolution);
        `BTC_EXT_RES:       avs_readdata <= 32'(external_total_resolution);
        `BTC_CLOSURE:       avs_readdata <= {16'h0,
                              pulse_closure_duration[1],
                              pulse_closure_duration[0]};
        `BTC_TOTAL1:        avs_readdata <= tot_count[0];
        `BTC_TOTAL2:        avs_readdata <= tot_count[1];
        `BTC_VERIFY_TOTAL:  avs_readdata <= tot_count[2];
        `BTC_MTEST_TOTAL:   avs_readdata <= tot_count[3];
        `BTC_BATCH_TOTAL:   avs_readdata <= tot_count[4];
        `BTC_PREACT_OFS:    avs_readdata <= preact_offset;
        `BTC_STATUS:        avs_readdata <= {7'h0,
                              scan_state != SCAN_IDLE, dur_eff[1],
                              dur_eff[0], ext_res_eff[1], ext_res_eff[0],
                              prewarn_relay, batch_relay};
        `BTC_DISPLAY: begin
          case (ctrl.total_display_select)
            2'h2:    avs_readdata <= tot_count[1];
            2'h3:    avs_readdata <= {tot_count[1][15:0],
                                      tot_count[0][15:0]};
            default: avs_readdata <= tot_count[0];
          endcase
        end
        default:            avs_readdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate gating

  // Dropout compare in tenths of a percent of design load
  assign drop_lhs = 64'(rate_sample) * 64'sd1000;
  assign drop_rhs = $signed(64'(totalize_dropout_limit) *
                            64'(design_rate));
  assign rate_pass = (totalize_dropout_limit == 32'h0) ||
                     (drop_lhs >= drop_rhs);
  // Verification mode 1 holds the main totalizers
  assign main_en = !(ctrl.verification_total_mode == 2'h1 &&
                     ctrl.verify_active);
  assign tot_en = {ctrl.batch_mode_select,
                   1'b1,
                   ctrl.verification_total_mode != 2'h0 &&
                   ctrl.verify_active,
                   main_en, main_en};

  ////////////////////////////////////////////////////////////////////////
  // Internal totalizers

  // Residue in thousandths becomes counts of the chosen step
  always_comb begin
    logic signed [31:0] sum;
    logic signed [31:0] st;
    sum = 32'sh0;
    st  = 32'sh0;
    for (int i = 0; i < 5; i++) begin
      st = $signed(step_of(internal_total_resolution[3*i +: 3]));
      sum = tot_resid[i] + ((rate_strobe && rate_pass && tot_en[i])
                            ? rate_sample : 32'sh0);
      next_count[i] = tot_count[i];
      next_resid[i] = sum;
      if (sum >= st) begin
        next_count[i] = tot_count[i] + 32'sh1;
        next_resid[i] = sum - st;
      end else if (sum <= -st) begin
        next_count[i] = tot_count[i] - 32'sh1;
        next_resid[i] = sum + st;
      end
    end
  end

  // Totalizer state with clear commands and batch reset
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (reset || (i == 1 && clr_cmd != 2'h0) ||
          (i == 0 && clr_cmd == 2'h2) || (i == 4 && batch_reset)) begin
        tot_count[i] <= 32'sh0;
        tot_resid[i] <= 32'sh0;
      end else begin
        tot_count[i] <= next_count[i];
        tot_resid[i] <= next_resid[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Batch control

  // Trip point set by the pre-act mode
  always_comb begin
    case (ctrl.preact_mode)
      2'h1:    trip_point = $signed(batch_target) - preact_offset;
      2'h2:    trip_point = $signed(batch_target -
                                    manual_preact_amount);
      default: trip_point = $signed(batch_target);
    endcase
  end

  // Automatic pre-act learns the overshoot at each batch reset
  always_ff @(posedge core_clk) begin
    logic signed [31:0] ofs;
    logic signed [31:0] lim;
    ofs = preact_offset + tot_count[4] - $signed(batch_target);
    lim = $signed(batch_target / 32'ha);
    if (reset)
      preact_offset <= 32'sh0;
    else if (batch_reset && ctrl.preact_mode == 2'h1) begin
      if (ofs > lim)
        preact_offset <= lim;
      else if (ofs < -lim)
        preact_offset <= -lim;
      else
        preact_offset <= ofs;
    end
  end

  // Relays: batch closed while running, pre-warn closed near the end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      batch_relay   <= 1'b0;
      prewarn_relay <= 1'b0;
    end else begin
      batch_relay   <= ctrl.batch_mode_select &&
                       tot_count[4] < trip_point;
      prewarn_relay <= ctrl.batch_mode_select &&
                       ctrl.prewarn_enable &&
                       tot_count[4] >= $signed(prewarn_target);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External totalizer closure timing

  // Effective resolution and duration of each output
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ext_res_eff[c] = eff_res(external_total_resolution[3*c +: 3],
                               design_rate);
      dur_eff[c] = (pulse_closure_duration[c] > dur_max100[c])
                   ? dur_max100[c] : pulse_closure_duration[c];
    end
  end

  // Scanner finds the longest durations that keep pace
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scan_state <= SCAN_IDLE;
      scan_d     <= 8'h0;
      dur_max150 <= '{8'hff, 8'hff};
      dur_max100 <= '{8'hff, 8'hff};
    end else if (scan_start) begin
      // A new rate or resolution restarts the scan, so no stale maximum
      // from the old settings survives into the loaded durations
      scan_state <= SCAN_RUN;
      scan_d     <= 8'h0;
      dur_max150 <= '{8'h0, 8'h0};
      dur_max100 <= '{8'h0, 8'h0};
    end else begin
      case (scan_state)
        SCAN_IDLE: scan_state <= SCAN_IDLE;
        SCAN_RUN: begin
          for (int c = 0; c < 2; c++) begin
            if (keeps_pace(scan_d, design_rate, ext_res_eff[c], 8'h96))
              dur_max150[c] <= scan_d;
            if (keeps_pace(scan_d, design_rate, ext_res_eff[c], 8'h64))
              dur_max100[c] <= scan_d;
          end
          scan_d <= scan_d + 8'h1;
          if (scan_d == 8'hff)
            scan_state <= SCAN_LOAD;
        end
        SCAN_LOAD: scan_state <= SCAN_IDLE;
        default:   scan_state <= SCAN_IDLE;
      endcase
    end
  end

  // Closure durations: software value or derived default
  always_ff @(posedge core_clk) begin
    if (reset)
      pulse_closure_duration <= '{`BTC_CLOSURE_RST,
                                  `BTC_CLOSURE_RST};
    else if (scan_state == SCAN_LOAD)
      pulse_closure_duration <= dur_max150;
    else if (wr && req.address == `BTC_CLOSURE) begin
      if (req.byteenable[0])
        pulse_closure_duration[0] <= req.writedata[7:0];
      if (req.byteenable[1])
        pulse_closure_duration[1] <= req.writedata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External totalizer pulse generators

  // Equal closed and open time, one pulse per resolution step
  always_ff @(posedge core_clk) begin
    logic signed [31:0] st;
    logic signed [31:0] add;
    logic [31:0]        len;
    for (int c = 0; c < 2; c++) begin
      st  = $signed(step_of(ext_res_eff[c]));
      add = (rate_strobe && rate_pass && main_en) ? rate_sample : 32'sh0;
      len = 32'(dur_eff[c]) * STEP_CYCLES;
      if (len == 32'h0)
        len = 32'h1;
      if (reset || clr_cmd == 2'h2) begin
        ext_resid[c] <= 32'sh0;
        ext_timer[c] <= 32'h0;
        ext_on[c]    <= 1'b0;
      end else if (ext_timer[c] > 32'h1) begin
        ext_timer[c] <= ext_timer[c] - 32'h1;
        ext_resid[c] <= ext_resid[c] + add;
      end else if (ext_on[c]) begin
        ext_on[c]    <= 1'b0;
        ext_timer[c] <= len;
        ext_resid[c] <= ext_resid[c] + add;
      end else if (ext_resid[c] >= st) begin
        ext_on[c]    <= 1'b1;
        ext_timer[c] <= len;
        ext_resid[c] <= ext_resid[c] + add - st;
      end else begin
        ext_timer[c] <= 32'h0;
        ext_resid[c] <= ext_resid[c] + add;
      end
    end
  end

  // Output contacts from flip-flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      external_count_one <= 1'b0;
      external_count_two <= 1'b0;
    end else begin
      external_count_one <= ext_on[0];
      external_count_two <= ext_on[1];
    end
  end

endmodule

// *** dv/btc_top_sva.sv ***
/* Port checker of the batch totalizer block.
   Assumes it is bound onto btc_top and sees only its ports. */
`timescale 1ns/100ps
module btc_top_sva (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        batch_relay,
  input wire logic        prewarn_relay,
  input wire logic        external_count_one,
  input wire logic        external_count_two
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  a_answer_cause: assert property ($fell(avs_waitrequest)
    |-> $past(avs_read || avs_write)) else $error("answer without cause");
  a_data_hold: assert property (avs_waitrequest && $past(avs_waitrequest)
    |-> $stable(avs_readdata)) else $error("read data moved while idle");
  a_reset_quiet: assert property ($fell(reset) |-> !batch_relay
    && !prewarn_relay && !external_count_one && !external_count_two
    && avs_waitrequest) else $error("outputs active after reset");
  a_gap_one: assert property ($fell(external_count_one)
    |=> !external_count_one) else $error("no open time on output one");
  a_gap_two: assert property ($fell(external_count_two)
    |=> !external_count_two) else $error("no open time on output two");
endmodule
bind btc_top btc_top_sva u_sva (.core_clk(core_clk), .reset(reset),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .batch_relay(batch_relay),
  .prewarn_relay(prewarn_relay), .external_count_one(external_count_one),
  .external_count_two(external_count_two));

// *** dv/btc_count_model.sv ***
/* External counters that take the totalizer contact closures.
   Assumes each closure is a high pulse on the output. */
`timescale 1ns/100ps
module btc_count_model (
  input wire logic external_count_one,
  input wire logic external_count_two,
  output int       ones,
  output int       twos
);
  initial ones = 0;
  initial twos = 0;
  // Each closure adds one step on the counter
  always @(posedge external_count_one) ones++;
  always @(posedge external_count_two) twos++;
endmodule

// *** dv/batch_totalizer_control_test.sv ***
/* Self-checking bench of the batch totalizer block.
   Assumes btc_top with short closure steps and the count model. */
`timescale 1ns/100ps
`include "btc_regs.svh"
module batch_totalizer_control_test;
  logic               core_clk, reset, avs_read, avs_write, rate_strobe;
  logic        [7:0]  avs_address;
  logic        [31:0] avs_writedata, rd_val;
  logic signed [31:0] rate_sample;
  wire         [31:0] avs_readdata;
  wire                avs_waitrequest, batch_relay, prewarn_relay, e1, e2;
  int                 errors, compares, cyc, ones, twos, b1, b2;
  btc_top #(.STEP_CYCLES(4)) uut (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rate_sample(rate_sample), .rate_strobe(rate_strobe),
    .batch_relay(batch_relay), .prewarn_relay(prewarn_relay),
    .external_count_one(e1), .external_count_two(e2));
  btc_count_model cnt (.external_count_one(e1), .external_count_two(e2),
    .ones(ones), .twos(twos));
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up;
    end
  end
  ////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Avalon cycle held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_val, e);
  endtask
  task smp(input int v);
    rate_sample <= v;
    rate_strobe <= 1'b1;
    @(posedge core_clk);
    rate_strobe <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  task batch_run(input logic [31:0] c, input int n, input int trip, pw);
    bus(1'b1, `BTC_COMMAND, 32'h4);
    bus(1'b1, `BTC_CTRL, c);
    for (int i = 1; i <= n; i++) begin
      smp(1000);
      if (c[0]) rdchk(`BTC_BATCH_TOTAL, 32'(i));
      chk(batch_relay, c[0] && i < trip);
      chk(prewarn_relay, c[0] && c[1] && i >= pw);
    end
  endtask
  task batch_modes;
    bus(1'b1, `BTC_BATCH_TARGET, 32'd10);
    bus(1'b1, `BTC_PREWARN_TGT, 32'd5);
    bus(1'b1, `BTC_MANUAL_PREACT, 32'd3);
    bus(1'b1, `BTC_DROPOUT, 32'd0);
    batch_run(32'h40, 2, 10, 5);
    batch_run(32'h43, 11, 10, 5);
    batch_run(32'h41, 6, 10, 5);
    batch_run(32'h4b, 8, 7, 5);
    batch_run(32'h47, 12, 10, 5);
    batch_run(32'h47, 10, 9, 5);
    rdchk(`BTC_PREACT_OFS, 32'd1);
  endtask
  task clears;
    bus(1'b1, `BTC_COMMAND, 32'h2);
    repeat (3) smp(1000);
    bus(1'b1, `BTC_COMMAND, 32'h1);
    rdchk(`BTC_TOTAL1, 32'd3);
    rdchk(`BTC_TOTAL2, 32'd0);
    bus(1'b1, `BTC_CTRL, 32'hc0);
    rdchk(`BTC_DISPLAY, 32'd3);
    smp(-1000);
    rdchk(`BTC_TOTAL1, 32'd2);
    bus(1'b1, `BTC_COMMAND, 32'h2);
    rdchk(`BTC_TOTAL1, 32'd0);
  endtask
  task pulses;
    repeat (600) @(posedge core_clk);
    b1 = ones;
    b2 = twos;
    repeat (3) smp(1000);
    repeat (600) @(posedge core_clk);
    chk(32'(ones - b1), 32'd3);
    chk(32'(twos - b2), 32'd3);
    // Two half steps around a clear must give no closure
    b1 = ones;
    smp(500);
    bus(1'b1, `BTC_COMMAND, 32'h2);
    smp(500);
    repeat (100) @(posedge core_clk);
    chk(32'(ones - b1), 32'd0);
  endtask
  // Dropout, fine resolutions, derived durations and verification modes
  task modes;
    bus(1'b1, `BTC_DESIGN_RATE, 32'd100);
    bus(1'b1, `BTC_DROPOUT, 32'd30);
    bus(1'b1, `BTC_INT_RES, 32'h4921);
    bus(1'b1, `BTC_COMMAND, 32'h2);
    smp(2);
    smp(3);
    rdchk(`BTC_TOTAL1, 32'd3);
    repeat (300) @(posedge core_clk);
    rdchk(`BTC_CLOSURE, 32'h0000_2121);
    bus(1'b1, `BTC_CLOSURE, 32'h3c3c);
    rdchk(`BTC_STATUS, 32'h0032_3290);
    bus(1'b1, `BTC_EXT_RES, 32'h9);
    repeat (300) @(posedge core_clk);
    rdchk(`BTC_STATUS, 32'h0003_036c);
    bus(1'b1, `BTC_INT_RES, 32'h4924);
    bus(1'b1, `BTC_CTRL, 32'h110);
    smp(1000);
    rdchk(`BTC_TOTAL1, 32'd3);
    rdchk(`BTC_VERIFY_TOTAL, 32'd1);
    bus(1'b1, `BTC_CTRL, 32'h120);
    smp(1000);
    rdchk(`BTC_TOTAL1, 32'd4);
    rdchk(`BTC_VERIFY_TOTAL, 32'd2);
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    rate_sample = 32'sh0;
    rate_strobe = 1'b0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rdchk(`BTC_CTRL, `BTC_CTRL_RST);
    rdchk(`BTC_DROPOUT, `BTC_DROPOUT_RST);
    rdchk(`BTC_CLOSURE, 32'h0000_0303);
    rdchk(8'h80, 32'h0);
    batch_modes;
    clears;
    pulses;
    modes;
    wrap_up;
  end
endmodule
